// ---- src/pcsst_consts.svh ----
// shared constants of the pcs receive status and test pattern block
`ifndef PCSST_CONSTS_SVH
`define PCSST_CONSTS_SVH

// ==========================================================================
// clock and timing
`define PCSST_CLK_MHZ        25
`define PCSST_BER_WIN_US     125
`define PCSST_BER_WIN_CYC    (`PCSST_BER_WIN_US * `PCSST_CLK_MHZ)
`define PCSST_BER_LIMIT      12'h061
`define PCSST_LOCK_GOOD      7'h40
`define PCSST_SLIP_WIN       6'h3f
`define PCSST_SLIP_BAD       5'h10

// ==========================================================================
// block coding
`define PCSST_HDR_DATA       2'h1
`define PCSST_HDR_CTRL       2'h2
`define PCSST_IDLE_BLOCK     64'h0000_0000_0000_001e
`define PCSST_SCR_TAP_A      38
`define PCSST_SCR_TAP_B      57
`define PCSST_SCR_SEED       58'h3ffffffffffffff
`define PCSST_BT_START       8'h78, 8'h33, 8'h66
`define PCSST_BT_TERM        8'h87, 8'h99, 8'haa, 8'hb4, 8'hcc, 8'hd2, 8'he1, 8'hff
`define PCSST_BT_OTHER       8'h1e, 8'h2d, 8'h4b, 8'h55

// ==========================================================================
// register map
`define PCSST_REG_CTRL       8'h00
`define PCSST_REG_MARK2_LO   8'h04
`define PCSST_REG_MARK2_HI   8'h08
`define PCSST_REG_MARK3_LO   8'h0c
`define PCSST_REG_MARK3_HI   8'h10
`define PCSST_REG_STATUS     8'h14
`define PCSST_CTRL_RX_TEST   0
`define PCSST_CTRL_TX_TEST   1
`define PCSST_ST_FIFO_ERR    0
`define PCSST_ST_LOCAL_FAULT 1
`define PCSST_ST_EXCESS_BER  2
`define PCSST_ST_ALIGNED     3
`define PCSST_ST_RX_STATUS   4
`define PCSST_ST_LOCK_LSB    8
`define PCSST_MARK_RESET     64'h0

`endif

// ---- src/pcsst_pkg.sv ----
// types of the pcs receive status and test pattern block
package pcsst_pkg;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic [1:0]  lane;
    logic [1:0]  hdr;
    logic [63:0] data;
  } pcsst_blk_t;

  typedef struct packed {
    logic        valid;
    logic        marker;
    logic [1:0]  lane;
    logic [1:0]  hdr;
    logic [63:0] data;
  } pcsst_txblk_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] count;
  } pcsst_lane_inc_t;

  typedef enum logic {
    PCSST_DEC_INIT,
    PCSST_DEC_RUN
  } pcsst_dec_state_t;

endpackage

// ---- src/pcsst_top.sv ----
// pcs receive status, statistics and test pattern logic with apb registers
// ==========================================================================
// What this block does
// - on lanes 2 and 3 transmit the 64-bit marker held in that lane's register
// - receive test enable checks incoming blocks against scrambled idle
// - transmit test enable replaces traffic with scrambled idle blocks
// - fifo error flag goes to 1 on clock compensation underflow or overflow
// - local fault is 1 while the receive decoder sits in its init state
// - excess bit error flag is 1 while the bad header rate exceeds the limit
// - excess bit error flag is mirrored as a status register bit
// - four block lock bits, one per lane, set once that lane locks
// - eight-bit mismatch increment, one cycle, counts mismatches of that cycle
// - mismatch increment stays zero unless receive test enable is set
// - mismatch valid marks the cycles in which the increment counts
// - two-bit increment counts invalid block types and illegal block sequences
// - code violation increment counts only when its valid flag is 1
// - per-lane four-bit sync header error increment valid with its flag
// - per-lane valid flag marks cycles where that lane's increment counts
// - aligned is 1 when all lanes are locked and deskewed
// - aligned at 0 means the receive path is in local fault
// - aligned is mirrored as a status register bit
// - receive status is 1 only when aligned and no excess error rate
//
// Implementation choices: the register offsets and register access over APB.
`include "pcsst_consts.svh"

module pcsst_top (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [7:0]                    paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire pcsst_pkg::pcsst_blk_t         rx_blk_i,
  input  wire logic [3:0]                    rx_deskewed_i,
  input  wire logic                          fifo_underflow_i,
  input  wire logic                          fifo_overflow_i,
  input  wire pcsst_pkg::pcsst_txblk_t       tx_blk_i,
  output pcsst_pkg::pcsst_blk_t              tx_blk_o,
  output logic                               fifo_error_o,
  output logic                               local_fault_o,
  output logic                               excess_bit_error_flag_o,
  output logic      [3:0]                    block_lock_o,
  output logic                               aligned_o,
  output logic                               rx_status_o,
  output logic      [7:0]                    test_mismatch_o,
  output logic                               test_mismatch_valid_o,
  output logic      [1:0]                    bad_code_o,
  output logic                               bad_code_valid_o,
  output pcsst_pkg::pcsst_lane_inc_t [3:0]   lane_inc_o
);

  // ========================================================================
  // functions
  // 64 bits of the x^58 + x^39 + 1 (de)scrambler; returns {state, data}
  function automatic logic [121:0] scramble(input logic [57:0] st, input logic [63:0] d,
                                            input logic descr);
    logic [57:0] s;
    logic [63:0] o;
    s = st;
    o = 64'h0;
    for (int i = 0; i < 64; i++) begin
      o[i] = d[i] ^ s[`PCSST_SCR_TAP_A] ^ s[`PCSST_SCR_TAP_B];
      s = {s[56:0], descr ? d[i] : o[i]};
    end
    return {s, o};
  endfunction

  // ========================================================================
  // apb slave
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [1:0]  ctrl_reg;
  logic [63:0] mark2_reg;
  logic [63:0] mark3_reg;
  logic [31:0] status_word;
  logic [31:0] rdata_mux;

  wire apb_setup  = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i & pready_reg;
  wire hit_ctrl   = (paddr_i == `PCSST_REG_CTRL);
  wire hit_m2lo   = (paddr_i == `PCSST_REG_MARK2_LO);
  wire hit_m2hi   = (paddr_i == `PCSST_REG_MARK2_HI);
  wire hit_m3lo   = (paddr_i == `PCSST_REG_MARK3_LO);
  wire hit_m3hi   = (paddr_i == `PCSST_REG_MARK3_HI);
  wire hit_stat   = (paddr_i == `PCSST_REG_STATUS);
  wire mapped     = hit_ctrl | hit_m2lo | hit_m2hi | hit_m3lo | hit_m3hi | hit_stat;
  wire wr_en      = apb_access & pwrite_i & mapped;
  wire rx_test    = ctrl_reg[`PCSST_CTRL_RX_TEST];
  wire tx_test    = ctrl_reg[`PCSST_CTRL_TX_TEST];

  assign rdata_mux = hit_ctrl ? {30'h0, ctrl_reg} :
                     hit_m2lo ? mark2_reg[31:0] :
                     hit_m2hi ? mark2_reg[63:32] :
                     hit_m3lo ? mark3_reg[31:0] :
                     hit_m3hi ? mark3_reg[63:32] :
                     hit_stat ? status_word : 32'h0;

  // no wait state: answer is prepared in the setup cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~mapped;
      prdata_reg  <= (apb_setup & ~pwrite_i) ? rdata_mux : 32'h0;
    end
  end

  // marker values are static: writes are ignored while the path is in reset, which clears them
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ctrl_reg  <= 2'h0;
      mark2_reg <= `PCSST_MARK_RESET;
      mark3_reg <= `PCSST_MARK_RESET;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_reg <= pwdata_i[1:0];
      if (hit_m2lo) mark2_reg[31:0] <= pwdata_i;
      if (hit_m2hi) mark2_reg[63:32] <= pwdata_i;
      if (hit_m3lo) mark3_reg[31:0] <= pwdata_i;
      if (hit_m3hi) mark3_reg[63:32] <= pwdata_i;
    end
  end

  // ========================================================================
  // transmit: markers on lanes 2 and 3, scrambled idle test pattern
  pcsst_pkg::pcsst_blk_t tx_reg;
  pcsst_pkg::pcsst_blk_t tx_next;
  logic [57:0]           tx_scr_reg;
  logic [121:0]          tx_scr_res;
  wire                   tx_hi_lane = tx_blk_i.lane[1];

  assign tx_scr_res = scramble(tx_scr_reg, `PCSST_IDLE_BLOCK, 1'b0);

  always_comb begin
    tx_next = '{valid: tx_blk_i.valid, lane: tx_blk_i.lane, hdr: tx_blk_i.hdr,
                data: tx_blk_i.data};
    if (tx_test) begin
      tx_next.hdr  = `PCSST_HDR_CTRL;
      tx_next.data = tx_scr_res[63:0];
    end else if (tx_blk_i.marker && tx_hi_lane) begin
      tx_next.hdr  = `PCSST_HDR_DATA;
      tx_next.data = tx_blk_i.lane[0] ? mark3_reg : mark2_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      tx_reg     <= '0;
      tx_scr_reg <= `PCSST_SCR_SEED;
    end else begin
      tx_reg <= tx_next;
      if (tx_test && tx_blk_i.valid) tx_scr_reg <= tx_scr_res[121:64];
    end
  end

  // ========================================================================
  // receive: per-lane block lock and sync header errors
  logic [3:0]            lock_reg;
  logic [3:0]            lock_next;
  logic [6:0]            good_reg [4];
  logic [6:0]            good_next [4];
  logic [5:0]            win_reg [4];
  logic [5:0]            win_next [4];
  logic [4:0]            bad_reg [4];
  logic [4:0]            bad_next [4];
  pcsst_pkg::pcsst_lane_inc_t [3:0] inc_reg;
  pcsst_pkg::pcsst_lane_inc_t [3:0] inc_next;
  wire hdr_ok = (rx_blk_i.hdr == `PCSST_HDR_DATA) | (rx_blk_i.hdr == `PCSST_HDR_CTRL);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lock_next[i] = lock_reg[i];
      good_next[i] = good_reg[i];
      win_next[i]  = win_reg[i];
      bad_next[i]  = bad_reg[i];
      inc_next[i]  = '0;
      if (rx_blk_i.valid && rx_blk_i.lane == 2'(i)) begin
        inc_next[i].valid = 1'b1;
        inc_next[i].count = {3'h0, ~hdr_ok};
        if (!lock_reg[i]) begin
          good_next[i] = hdr_ok ? good_reg[i] + 7'h1 : 7'h0;
          if (hdr_ok && good_next[i] == `PCSST_LOCK_GOOD) begin
            lock_next[i] = 1'b1;
            good_next[i] = 7'h0;
          end
        end else begin
          bad_next[i] = bad_reg[i] + {4'h0, ~hdr_ok};
          win_next[i] = win_reg[i] + 6'h1;
          if (bad_next[i] == `PCSST_SLIP_BAD) begin
            lock_next[i] = 1'b0;
            bad_next[i]  = 5'h0;
            win_next[i]  = 6'h0;
          end else if (win_reg[i] == `PCSST_SLIP_WIN) begin
            bad_next[i] = 5'h0;
          end
        end
      end
    end
  end

  // ========================================================================
  // receive: error rate monitor over a fixed time window
  logic [11:0] ber_win_reg;
  logic [11:0] ber_cnt_reg;
  logic        excess_reg;
  wire         ber_tick   = (ber_win_reg == 12'(`PCSST_BER_WIN_CYC - 1));
  wire         bad_hdr    = rx_blk_i.valid & ~hdr_ok;
  wire         ber_over   = (ber_cnt_reg > `PCSST_BER_LIMIT);
  wire         excess_next = ber_tick ? ber_over : excess_reg;

  // ========================================================================
  // receive: decoder, code violations and test pattern checker
  pcsst_pkg::pcsst_dec_state_t dec_state_reg;
  pcsst_pkg::pcsst_dec_state_t dec_state_next;
  logic         in_frame_reg;
  logic         in_frame_next;
  logic         code_err;
  logic [57:0]  rx_scr_reg;
  logic [121:0] rx_scr_res;
  logic         fifo_err_reg;
  logic         fault_reg;
  logic         aligned_reg;
  logic         rxstat_reg;
  logic [7:0]   mism_reg;
  logic         mism_val_reg;
  logic [1:0]   bad_code_reg;
  logic         bad_val_reg;
  // block type only has meaning once the payload is descrambled
  wire  [7:0]   btype      = rx_scr_res[7:0];
  wire          is_ctrl    = rx_blk_i.hdr == `PCSST_HDR_CTRL;
  wire          aligned_next = (&lock_next) & (&rx_deskewed_i);
  wire          test_chk   = rx_test & rx_blk_i.valid;
  wire          mismatch   = ~is_ctrl | (rx_scr_res[63:0] != `PCSST_IDLE_BLOCK);

  assign rx_scr_res = scramble(rx_scr_reg, rx_blk_i.data, 1'b1);

  always_comb begin
    in_frame_next = in_frame_reg;
    code_err      = 1'b0;
    if (rx_blk_i.valid) begin
      if (!hdr_ok) begin
        code_err      = 1'b1;
        in_frame_next = 1'b0;
      end else if (!is_ctrl) begin
        code_err = ~in_frame_reg;
      end else begin
        case (btype)
          `PCSST_BT_START: begin
            code_err      = in_frame_reg;
            in_frame_next = 1'b1;
          end
          `PCSST_BT_TERM: begin
            code_err      = ~in_frame_reg;
            in_frame_next = 1'b0;
          end
          `PCSST_BT_OTHER: begin
            code_err      = in_frame_reg;
            in_frame_next = 1'b0;
          end
          default: begin
            code_err      = 1'b1;
            in_frame_next = 1'b0;
          end
        endcase
      end
    end
  end

  always_comb begin
    case (dec_state_reg)
      pcsst_pkg::PCSST_DEC_INIT:
        dec_state_next = (aligned_next && !excess_next) ? pcsst_pkg::PCSST_DEC_RUN
                                                        : pcsst_pkg::PCSST_DEC_INIT;
      pcsst_pkg::PCSST_DEC_RUN:
        dec_state_next = (aligned_next && !excess_next) ? pcsst_pkg::PCSST_DEC_RUN
                                                        : pcsst_pkg::PCSST_DEC_INIT;
      default: dec_state_next = pcsst_pkg::PCSST_DEC_INIT;
    endcase
  end

  // synchronous reset on the receive clock clears every status output except local fault, which it sets to 1
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 4; i++) begin
        good_reg[i] <= 7'h0;
        win_reg[i]  <= 6'h0;
        bad_reg[i]  <= 5'h0;
      end
      lock_reg      <= 4'h0;
      inc_reg       <= '0;
      ber_win_reg   <= 12'h0;
      ber_cnt_reg   <= 12'h0;
      excess_reg    <= 1'b0;
      dec_state_reg <= pcsst_pkg::PCSST_DEC_INIT;
      in_frame_reg  <= 1'b0;
      rx_scr_reg    <= `PCSST_SCR_SEED;
      fifo_err_reg  <= 1'b0;
      fault_reg     <= 1'b1;
      aligned_reg   <= 1'b0;
      rxstat_reg    <= 1'b0;
      mism_reg      <= 8'h0;
      mism_val_reg  <= 1'b0;
      bad_code_reg  <= 2'h0;
      bad_val_reg   <= 1'b0;
    end else begin
      good_reg      <= good_next;
      win_reg       <= win_next;
      bad_reg       <= bad_next;
      lock_reg      <= lock_next;
      inc_reg       <= inc_next;
      ber_win_reg   <= ber_tick ? 12'h0 : ber_win_reg + 12'h1;
      // saturate so a burst of errors cannot wrap below the limit
      ber_cnt_reg   <= ber_tick ? 12'h0 : ber_cnt_reg + {11'h0, bad_hdr & ~&ber_cnt_reg};
      excess_reg    <= excess_next;
      dec_state_reg <= dec_state_next;
      in_frame_reg  <= in_frame_next;
      if (rx_blk_i.valid) rx_scr_reg <= rx_scr_res[121:64];
      // sticky until reset: the fifo cannot recover by itself
      fifo_err_reg  <= fifo_err_reg | fifo_underflow_i | fifo_overflow_i;
      fault_reg     <= (dec_state_next == pcsst_pkg::PCSST_DEC_INIT);
      aligned_reg   <= aligned_next;
      rxstat_reg    <= aligned_next & ~excess_next;
      mism_reg      <= test_chk ? {7'h0, mismatch} : 8'h0;
      mism_val_reg  <= test_chk;
      bad_code_reg  <= {1'b0, code_err};
      bad_val_reg   <= rx_blk_i.valid;
    end
  end

  // ========================================================================
  // status word and outputs
  assign status_word = {20'h0, lock_reg, 3'h0, rxstat_reg, aligned_reg,
                        excess_reg, fault_reg, fifo_err_reg};

  assign prdata_o                = prdata_reg;
  assign pready_o                = pready_reg;
  assign pslverr_o               = pslverr_reg;
  assign tx_blk_o                = tx_reg;
  assign fifo_error_o            = fifo_err_reg;
  assign local_fault_o           = fault_reg;
  assign excess_bit_error_flag_o = excess_reg;
  assign block_lock_o            = lock_reg;
  assign aligned_o               = aligned_reg;
  assign rx_status_o             = rxstat_reg;
  assign test_mismatch_o         = mism_reg;
  assign test_mismatch_valid_o   = mism_val_reg;
  assign bad_code_o              = bad_code_reg;
  assign bad_code_valid_o        = bad_val_reg;
  assign lane_inc_o              = inc_reg;

  // ========================================================================
  // assertions
  sequence s_marker_slot2;
    tx_blk_i.valid && tx_blk_i.marker && tx_blk_i.lane == 2'h2 && !tx_test;
  endsequence

  a_marker_lane2: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_marker_slot2 |=> (tx_blk_o.data == $past(mark2_reg) && tx_blk_o.hdr == `PCSST_HDR_DATA))
    else $error("lane 2 marker not inserted");
  a_tx_test_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    tx_test |=> tx_blk_o.hdr == `PCSST_HDR_CTRL)
    else $error("tx test pattern header wrong");
  a_fifo_err_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (fifo_underflow_i || fifo_overflow_i) |=> fifo_error_o [*3])
    else $error("fifo error not flagged");
  a_fault_init: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    local_fault_o == (dec_state_reg == pcsst_pkg::PCSST_DEC_INIT))
    else $error("local fault out of step with decoder");
  a_excess_ber: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ber_tick |=> excess_bit_error_flag_o == $past(ber_over))
    else $error("excess error flag wrong after window");
  a_lock_count: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(block_lock_o[0]) |-> $past(good_reg[0]) == `PCSST_LOCK_GOOD - 7'h1)
    else $error("lane 0 locked too early");
  a_mismatch_off: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !rx_test |=> (test_mismatch_o == 8'h0 && !test_mismatch_valid_o))
    else $error("mismatch active without test enable");
  a_mismatch_cnt: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (test_chk && !is_ctrl) |=> (test_mismatch_o == 8'h1 && test_mismatch_valid_o))
    else $error("data block not counted as mismatch");
  a_code_valid: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    bad_code_o != 2'h0 |-> bad_code_valid_o)
    else $error("code violation without valid");
  a_lane_valid: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (rx_blk_i.valid && !hdr_ok && rx_blk_i.lane == 2'h3) |=>
      (lane_inc_o[3].valid && lane_inc_o[3].count == 4'h1))
    else $error("lane 3 header error not reported");
  a_aligned_fault: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !aligned_o |-> local_fault_o)
    else $error("misaligned without local fault");
  a_status_combo: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    rx_status_o == (aligned_o && !excess_bit_error_flag_o))
    else $error("receive status inconsistent");

endmodule

// ---- dv/pcsst_mon.sv ----
// far-side statistics counters that accumulate the status increments
module pcsst_mon (
  input  wire logic                             core_clk_i,
  input  wire logic                             clr_b_i,
  input  wire pcsst_pkg::pcsst_lane_inc_t [3:0] lane_inc_i,
  input  wire logic [7:0]                       mis_i,
  input  wire logic                             mis_valid_i,
  input  wire logic [1:0]                       bad_i,
  input  wire logic                             bad_valid_i,
  output logic      [15:0]                      mis_total_o,
  output logic      [15:0]                      bad_total_o,
  output logic      [15:0]                      hdr_total_o
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [15:0] hsum(input pcsst_pkg::pcsst_lane_inc_t [3:0] v);
    hsum = 16'h0;
    for (int i = 0; i < 4; i++)
      if (v[i].valid)
        hsum = hsum + 16'(v[i].count);
  endfunction
  // an increment without its valid flag is noise and must not count
  always_ff @(posedge core_clk_i) begin
    if (!clr_b_i) begin
      mis_total_o <= 16'h0;
      bad_total_o <= 16'h0;
      hdr_total_o <= 16'h0;
    end else begin
      if (mis_valid_i)
        mis_total_o <= mis_total_o + 16'(mis_i);
      if (bad_valid_i)
        bad_total_o <= bad_total_o + 16'(bad_i);
      hdr_total_o <= hdr_total_o + hsum(lane_inc_i);
    end
  end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the pcs status and test pattern block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        fifo_underflow_i, fifo_overflow_i, fifo_error_o, local_fault_o, aligned_o;
  logic        excess_bit_error_flag_o, rx_status_o, test_mismatch_valid_o, bad_code_valid_o;
  logic        se, loop, inj_on, mon_clr_b;
  logic [1:0]  bad_code_o, tx_lane;
  logic [3:0]  rx_deskewed_i, block_lock_o;
  logic [7:0]  paddr_i, test_mismatch_o;
  logic [15:0] mis_tot, bad_tot, hdr_tot;
  logic [31:0] pwdata_i, prdata_o, rd, rnd;
  logic [63:0] mk [4];
  int          err_total, cmp_count;
  pcsst_pkg::pcsst_blk_t            rx_blk_i, tx_blk_o;
  pcsst_pkg::pcsst_txblk_t          tx_blk_i;
  pcsst_pkg::pcsst_lane_inc_t [3:0] lane_inc_o;
  // =========
  // design and counters
  pcsst_top u_dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_blk_i(rx_blk_i),
    .rx_deskewed_i(rx_deskewed_i), .fifo_underflow_i(fifo_underflow_i),
    .fifo_overflow_i(fifo_overflow_i), .tx_blk_i(tx_blk_i), .tx_blk_o(tx_blk_o),
    .fifo_error_o(fifo_error_o), .local_fault_o(local_fault_o),
    .excess_bit_error_flag_o(excess_bit_error_flag_o), .block_lock_o(block_lock_o),
    .aligned_o(aligned_o), .rx_status_o(rx_status_o), .test_mismatch_o(test_mismatch_o),
    .test_mismatch_valid_o(test_mismatch_valid_o), .bad_code_o(bad_code_o),
    .bad_code_valid_o(bad_code_valid_o), .lane_inc_o(lane_inc_o));
  pcsst_mon u_mon (.core_clk_i(core_clk_i), .clr_b_i(mon_clr_b), .lane_inc_i(lane_inc_o),
    .mis_i(test_mismatch_o), .mis_valid_i(test_mismatch_valid_o), .bad_i(bad_code_o),
    .bad_valid_i(bad_code_valid_o), .mis_total_o(mis_tot), .bad_total_o(bad_tot),
    .hdr_total_o(hdr_tot));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // =========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] st_exp(input logic ff, lf, eb, al, rs, input logic [3:0] lk);
    return {20'h0, lk, 3'h0, rs, al, eb, lf, ff};
  endfunction
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      report_and_stop();
    end
    rd = prdata_o;
    se = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rst_pulse();
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk("fault in reset", 1, local_fault_o);
    chk("zero in reset", 0, {fifo_error_o, excess_bit_error_flag_o, block_lock_o, aligned_o,
        rx_status_o, test_mismatch_o, bad_code_o, lane_inc_o});
    rst_b_i <= 1'b1;
  endtask
  // zero the header of one looped block; its data stays intact so descrambling holds
  task automatic inj(input int pre, input logic [7:0] mexp);
    logic [1:0] ln;
    repeat (pre + 1) @(posedge core_clk_i);
    inj_on <= 1'b1;
    @(posedge core_clk_i);
    ln = tx_blk_o.lane;
    inj_on <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk("lane inc", 64'h11, 64'(lane_inc_o[ln]));
    chk("code inc", 3'h5, {bad_code_valid_o, bad_code_o});
    chk("mismatch", mexp, test_mismatch_o);
  endtask
  always @(posedge core_clk_i) begin
    if (loop) begin
      rnd = lfsr(rnd);
      tx_blk_i <= '{1'b1, 1'b0, tx_lane, 2'h2, {rnd, ~rnd}};
      tx_lane <= tx_lane + 2'h1;
      rx_blk_i <= '{tx_blk_o.valid, tx_blk_o.lane, inj_on ? 2'h0 : tx_blk_o.hdr, tx_blk_o.data};
    end
  end
  // =========
  // main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, fifo_underflow_i, fifo_overflow_i} = 5'h0;
    {loop, inj_on, mon_clr_b, tx_lane, paddr_i, pwdata_i} = 45'h0;
    {rx_blk_i, tx_blk_i} = '0;
    rx_deskewed_i = 4'hf;
    rnd = 32'h0000_004e;
    err_total = 0;
    cmp_count = 0;
    rst_pulse();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 0, rd);
    for (int l = 2; l < 4; l++) begin
      rnd = lfsr(rnd);
      mk[l] = {rnd, ~rnd ^ 32'h0000_00ff};
      apb(1'b1, 8'h04 + 8'(8 * (l - 2)), mk[l][31:0]);
      apb(1'b1, 8'h08 + 8'(8 * (l - 2)), mk[l][63:32]);
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk("marker read", mk[3][31:0], rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 3'h4, {se, rd[1:0]});
    for (int l = 0; l < 4; l++) begin
      rnd = lfsr(rnd);
      tx_blk_i <= '{1'b1, 1'b1, 2'(l), 2'h2, {rnd, rnd}};
      repeat (2) @(posedge core_clk_i);
      chk("tx data", (l >= 2) ? mk[l] : {rnd, rnd}, tx_blk_o.data);
      chk("tx hdr", (l >= 2) ? 2'h1 : 2'h2, tx_blk_o.hdr);
    end
    apb(1'b1, 8'h00, 32'h3);
    loop <= 1'b1;
    repeat (300) @(posedge core_clk_i);
    chk("lock", 4'hf, block_lock_o);
    chk("up", 4'hd, {aligned_o, rx_status_o, local_fault_o, tx_blk_o.hdr[1]});
    apb(1'b0, 8'h14, 32'h0);
    chk("status", st_exp(0, 0, 0, 1, 1, 4'hf), rd);
    mon_clr_b <= 1'b1;
    for (int i = 0; i < 4; i++)
      inj(i, 8'h1);
    apb(1'b1, 8'h00, 32'h2);
    inj(0, 8'h0);
    rx_deskewed_i <= 4'h7;
    repeat (3) @(posedge core_clk_i);
    chk("deskew lost", 3'h2, {aligned_o, local_fault_o, rx_status_o});
    rx_deskewed_i <= 4'hf;
    chk("totals", {16'h4, 16'h5, 16'h5}, {mis_tot, bad_tot, hdr_tot});
    loop <= 1'b0;
    for (int i = 0; i < 200; i++) begin
      @(posedge core_clk_i);
      rnd = lfsr(rnd);
      rx_blk_i <= '{1'b1, 2'(i), 2'h0, {rnd, rnd}};
    end
    @(posedge core_clk_i);
    rx_blk_i.valid <= 1'b0;
    for (int n = 0; n < 7000 && excess_bit_error_flag_o !== 1'b1; n++)
      @(posedge core_clk_i);
    chk("excess", 1, excess_bit_error_flag_o);
    chk("fault", 2'h1, {rx_status_o, local_fault_o});
    apb(1'b0, 8'h14, 32'h0);
    chk("status ber", st_exp(0, 1, 1, 0, 0, 4'h0), rd);
    fifo_underflow_i <= 1'b1;
    @(posedge core_clk_i);
    fifo_underflow_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk("fifo under", 1, fifo_error_o);
    rst_pulse();
    fifo_overflow_i <= 1'b1;
    @(posedge core_clk_i);
    fifo_overflow_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk("fifo over", 1, fifo_error_o);
    report_and_stop();
  end
endmodule
